// [src/wws_windowed_supervisor.sv]
// Windowed supervisor: counter, window check, reset pulse and registers
`default_nettype none
// Contract
// - Counter steps down once per prescaler period of 16384 oscillator cycles.
// - When active, stepping 40h to 3Fh starts a reset pulse.
// - When active, reloading while count exceeds window value causes reset.
// - Software option: starts off, activation bit enables until next reset.
// - Hardware option: always active, activation bit ignored.
// - Counter keeps counting whether enabled or not.
// - Writing activation set with top bit clear is a software reset.
// - Active with reset-on-halt option: HALT causes reset instead.
// - Six low counter bits give 64 timeout steps.
// - First interval after write lies between (LSB+128)x64 and 16384 clocks.
// - Timebase selection picks MSB/LSB pairs 4/59, 8/53, 20/35, 49/54.
// - Every floor(4*CNT/MSB) group takes (192+LSB)x64 clocks instead.
// - Control holds activation at bit 7, counter bits 6:0, resets 7Fh.
// - Activation bit set only by software, cleared only by reset.
// - After halt wake-up, counting resumes after 256 or 4096 clocks.
module wws_windowed_supervisor import wws_pkg::*; (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic              HW_ACTIVATE_OPT,
  input  wire logic              HALT_RESET_OPTION,
  input  wire logic              HALT_EXEC,
  input  wire logic              WAKE_IRQ,
  input  wire logic              RESUME_LONG_SEL,
  input  wire logic [1:0]        TIMEBASE_SELECT,
  output logic                   SUPERVISOR_RESET_N,
  output logic                   IRQ
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  logic             halt_s3_q;
  logic             wake_s3_q;

  assign pin_raw = {TIMEBASE_SELECT, RESUME_LONG_SEL, WAKE_IRQ, HALT_EXEC,
                    HALT_RESET_OPTION, HW_ACTIVATE_OPT};

  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge CLK) begin
      if (SYS_RST) begin
        pin_s1_q[i] <= 1'b0;
        pin_s2_q[i] <= 1'b0;
      end else begin
        pin_s1_q[i] <= pin_raw[i];
        pin_s2_q[i] <= pin_s1_q[i];
      end
    end
  end

  wire       hw_opt     = pin_s2_q[0];
  wire       halt_opt   = pin_s2_q[1];
  wire       halt_rise  = pin_s2_q[2] && !halt_s3_q;
  wire       wake_rise  = pin_s2_q[3] && !wake_s3_q;
  wire       resume_lng = pin_s2_q[4];
  wire [1:0] tb_sel     = pin_s2_q[6:5];

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  wws_wr_t           wr;
  logic              wr_fire;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;

  wire map_ctrl_w = wr.addr == ADDR_CTRL;
  wire map_win_w  = wr.addr == ADDR_WIN;
  wire map_stat_w = wr.addr == ADDR_STAT;
  wire map_mask_w = wr.addr == ADDR_MASK;
  wire wr_ok      = map_ctrl_w || map_win_w || map_stat_w || map_mask_w
                    || wr.addr == ADDR_INFO;
  wire lo_lane    = wr_fire && wr.strb[0];
  wire ctrl_wr    = lo_lane && map_ctrl_w;
  wire win_wr     = lo_lane && map_win_w;
  wire stat_wr    = lo_lane && map_stat_w;
  wire mask_wr    = lo_lane && map_mask_w;
  wire rd_ok      = rd_addr == ADDR_CTRL || rd_addr == ADDR_WIN || rd_addr == ADDR_STAT
                    || rd_addr == ADDR_MASK || rd_addr == ADDR_INFO;

  wws_axil u_axil (
    .clk     (CLK),
    .rst     (SYS_RST),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .wr      (wr),
    .wr_fire (wr_fire),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [6:0]        cnt_q;
  logic              act_bit_q;
  logic [6:0]        win_q;
  logic [STAT_W-1:0] stat_q;
  logic [STAT_W-1:0] mask_q;
  logic [11:0]       rst_cnt_q;
  logic              rst_n_q;
  logic [5:0]        acc_q;
  logic              first_q;
  logic [12:0]       resume_q;
  wws_halt_t         halt_st_q;
  wws_halt_t         halt_st_d;
  logic              tick;

  wire active = hw_opt || act_bit_q;

  // ----------------------------------------------------------------
  // Prescaler pacing
  // ----------------------------------------------------------------
  wire [5:0]  tb_msb    = TB_MSB[tb_sel];
  wire [7:0]  tb_lsb    = TB_LSB[tb_sel];
  wire [14:0] min_first = {1'b0, 8'(tb_lsb + MIN_BASE), 6'h00};
  wire [14:0] short_len = {1'b0, 8'(tb_lsb + SHORT_BASE), 6'h00};
  // A short step every time the running 4*n crosses a multiple of MSB
  wire [6:0]  acc_sum   = {1'b0, acc_q} + {1'b0, STEP_WEIGHT};
  wire        acc_wrap  = acc_sum >= {1'b0, tb_msb};
  wire [5:0]  acc_next  = acc_wrap ? 6'(acc_sum - {1'b0, tb_msb}) : acc_sum[5:0];
  wire [5:0]  acc_d     = ctrl_wr ? 6'h00 : (tick && !first_q) ? acc_next : acc_q;
  wire [6:0]  look_sum  = {1'b0, acc_d} + {1'b0, STEP_WEIGHT};
  wire        next_short = look_sum >= {1'b0, tb_msb};
  wire [14:0] period    = next_short ? short_len : PRESC_PERIOD;

  wws_prescaler u_presc (
    .clk      (CLK),
    .rst      (SYS_RST),
    .load_min (ctrl_wr),
    .min_cnt  (min_first),
    .period   (period),
    .tick     (tick)
  );

  // ----------------------------------------------------------------
  // Reset causes
  // ----------------------------------------------------------------
  wire count_en = halt_st_q == ST_RUN || halt_st_q == ST_HALT;
  wire step     = tick && count_en && !ctrl_wr;
  wire act_wr   = hw_opt || act_bit_q || wr.data[CTRL_ACT];
  wire exp_ev   = active && step && cnt_q == CNT_EXPIRE;
  wire win_ev   = ctrl_wr && active && cnt_q > win_q;
  wire soft_ev  = ctrl_wr && act_wr && !wr.data[CTRL_TOP];
  wire halt_ev  = halt_rise && active && halt_opt;
  wire [STAT_W-1:0] events = {halt_ev, soft_ev, win_ev, exp_ev};
  wire fire     = |events;
  wire busy     = rst_cnt_q != 12'h000;
  // A second cause during a pulse does not stretch it
  wire [11:0] rst_cnt_d = (fire && !busy) ? RST_PULSE_CYC
                          : busy ? rst_cnt_q - 12'h001 : 12'h000;

  // ----------------------------------------------------------------
  // Halt sequencing
  // ----------------------------------------------------------------
  always_comb begin
    halt_st_d = halt_st_q;
    case (halt_st_q)
      ST_RUN: begin
        if (halt_rise && !(active && halt_opt)) begin
          halt_st_d = ST_HALT;
        end
      end
      ST_HALT: begin
        if (wake_rise) begin
          halt_st_d = ST_RESUME;
        end else if (tick) begin
          halt_st_d = ST_FROZEN;
        end
      end
      ST_FROZEN: begin
        if (wake_rise) begin
          halt_st_d = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (resume_q == 13'h0001) begin
          halt_st_d = ST_RUN;
        end
      end
      default: halt_st_d = ST_RUN;
    endcase
  end

  wire [12:0] resume_d = (halt_st_d == ST_RESUME && halt_st_q != ST_RESUME)
                         ? (resume_lng ? RESUME_LONG : RESUME_SHORT)
                         : (resume_q != 13'h0000) ? resume_q - 13'h0001 : 13'h0000;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  wire [6:0] cnt_d = ctrl_wr ? wr.data[6:0] : step ? cnt_q - 7'h01 : cnt_q;
  wire [STAT_W-1:0] stat_d = (stat_q & ~(stat_wr ? wr.data[STAT_W-1:0] : '0)) | events;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cnt_q     <= CNT_RESET;
      act_bit_q <= 1'b0;
      win_q     <= WIN_RESET;
      stat_q    <= '0;
      mask_q    <= '0;
      rst_cnt_q <= 12'h000;
      rst_n_q   <= 1'b1;
      acc_q     <= 6'h00;
      first_q   <= 1'b1;
      resume_q  <= 13'h0000;
      halt_st_q <= ST_RUN;
      halt_s3_q <= 1'b0;
      wake_s3_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      act_bit_q <= act_bit_q || (ctrl_wr && wr.data[CTRL_ACT]);
      win_q     <= win_wr ? wr.data[6:0] : win_q;
      stat_q    <= stat_d;
      mask_q    <= mask_wr ? wr.data[STAT_W-1:0] : mask_q;
      rst_cnt_q <= rst_cnt_d;
      rst_n_q   <= rst_cnt_d == 12'h000;
      acc_q     <= acc_d;
      first_q   <= ctrl_wr || (first_q && !tick);
      resume_q  <= resume_d;
      halt_st_q <= halt_st_d;
      halt_s3_q <= pin_s2_q[2];
      wake_s3_q <= pin_s2_q[3];
    end
  end

  assign SUPERVISOR_RESET_N = rst_n_q;
  assign IRQ = |(stat_q & mask_q);

  wire [2:0] info = {busy, halt_st_q != ST_RUN, active};
  assign rd_data = rd_addr == ADDR_CTRL ? {24'h000000, act_bit_q, cnt_q}
                 : rd_addr == ADDR_WIN  ? {25'h0000000, win_q}
                 : rd_addr == ADDR_STAT ? {28'h0000000, stat_q}
                 : rd_addr == ADDR_MASK ? {28'h0000000, mask_q}
                 : rd_addr == ADDR_INFO ? {29'h00000000, info}
                 : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_expiry_reset: assert property (exp_ev && !busy |=> !SUPERVISOR_RESET_N)
    else $error("expiry did not start reset pulse");
  a_pulse_hold: assert property ($fell(SUPERVISOR_RESET_N) |-> !SUPERVISOR_RESET_N[*8])
    else $error("reset pulse too short");
  a_window_reset: assert property (win_ev |=> stat_q[STAT_WINDOW])
    else $error("early reload not flagged");
  a_soft_reset: assert property (ctrl_wr && wr.data[CTRL_ACT] && !wr.data[CTRL_TOP]
    |=> stat_q[STAT_SOFT])
    else $error("software reset missed");
  a_act_sticky: assert property (act_bit_q |=> act_bit_q)
    else $error("activation bit cleared without reset");
  a_hw_active: assert property (hw_opt && ctrl_wr && cnt_q > win_q |=> stat_q[STAT_WINDOW])
    else $error("hardware option did not guard the window");
  a_free_run: assert property (step |=> cnt_q == 7'($past(cnt_q) - 7'h01))
    else $error("counter did not step");
  a_halt_reset: assert property (halt_rise && active && halt_opt
    |=> stat_q[STAT_HALT] && halt_st_q == ST_RUN)
    else $error("halt did not reset");
  a_step_spacing: assert property (tick |=> !tick[*8])
    else $error("prescaler ticks too close");
  a_resume_wait: assert property (wake_rise && (halt_st_q == ST_HALT || halt_st_q == ST_FROZEN)
    |=> halt_st_q == ST_RESUME [*8])
    else $error("resumed counting too soon");
endmodule // wws_windowed_supervisor
`default_nettype wire

// [src/wws_pkg.sv]
// Constants and carrier types for the windowed supervisor
`default_nettype none
package wws_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned RST_PULSE_NS  = 30000;
  localparam logic [11:0] RST_PULSE_CYC = 12'(RST_PULSE_NS / CLK_PERIOD_NS);
  localparam logic [14:0] PRESC_PERIOD  = 15'h4000;
  localparam logic [7:0]  MIN_BASE      = 8'h80;
  localparam logic [7:0]  SHORT_BASE    = 8'hC0;
  localparam logic [5:0]  STEP_WEIGHT   = 6'h04;
  localparam logic [12:0] RESUME_SHORT  = 13'h0100;
  localparam logic [12:0] RESUME_LONG   = 13'h1000;
  // Timebase table, indexed by timebase_select
  localparam logic [3:0][5:0] TB_MSB = {6'h31, 6'h14, 6'h08, 6'h04};
  localparam logic [3:0][7:0] TB_LSB = {8'h36, 8'h23, 8'h35, 8'h3B};

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 8;
  localparam logic [7:0]  ADDR_CTRL = 8'h00;
  localparam logic [7:0]  ADDR_WIN  = 8'h04;
  localparam logic [7:0]  ADDR_STAT = 8'h08;
  localparam logic [7:0]  ADDR_MASK = 8'h0C;
  localparam logic [7:0]  ADDR_INFO = 8'h10;
  localparam int unsigned CTRL_ACT  = 7;
  localparam int unsigned CTRL_TOP  = 6;
  localparam logic [6:0]  CNT_RESET = 7'h7F;
  localparam logic [6:0]  CNT_EXPIRE = 7'h40;
  localparam logic [6:0]  WIN_RESET = 7'h7F;
  localparam int unsigned STAT_EXPIRE = 0;
  localparam int unsigned STAT_WINDOW = 1;
  localparam int unsigned STAT_SOFT   = 2;
  localparam int unsigned STAT_HALT   = 3;
  localparam int unsigned STAT_W      = 4;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Pin bundle width for the synchroniser
  localparam int unsigned PIN_W = 7;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } wws_wr_t;

  typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_FROZEN, ST_RESUME} wws_halt_t;
endpackage
`default_nettype wire

// [src/wws_prescaler.sv]
// Free-running prescaler that paces the supervisor counter
`default_nettype none
module wws_prescaler import wws_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        load_min,
  input  wire logic [14:0] min_cnt,
  input  wire logic [14:0] period,
  output logic             tick
);
  logic [14:0] rem_q;
  logic [14:0] rem_d;

  // Phase is never cleared by a write, only stretched to the least interval
  assign tick = (rem_q == 15'h0001);

  always_comb begin
    rem_d = tick ? period : rem_q - 15'h0001;
    if (load_min && rem_d < min_cnt) begin
      rem_d = min_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rem_q <= PRESC_PERIOD;
    end else begin
      rem_q <= rem_d;
    end
  end

  a_first_interval: assert property (@(posedge clk) disable iff (rst)
    load_min |=> (rem_q >= $past(min_cnt) && rem_q <= PRESC_PERIOD))
    else $error("first interval after write out of range");
endmodule // wws_prescaler
`default_nettype wire

// [src/wws_axil.sv]
// AXI4-Lite slave front end for the supervisor registers
`default_nettype none
module wws_axil import wws_pkg::*; (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output wws_wr_t                wr,
  output logic                   wr_fire,
  input  wire logic              wr_ok,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_ok
);
  logic aw_full_q;
  logic w_full_q;
  logic rd_fire;
  wws_wr_t wr_q;

  assign awready = !aw_full_q;
  assign wready  = !w_full_q;
  assign arready = !rvalid;
  assign rd_fire = arvalid && !rvalid;
  assign rd_addr = araddr;
  // Both halves held; the response slot must be free before committing
  assign wr_fire = aw_full_q && w_full_q && !bvalid;
  assign wr      = wr_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      wr_q      <= '0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      rvalid    <= 1'b0;
      rdata     <= 32'h0000_0000;
      rresp     <= RESP_OKAY;
    end else begin
      if (awvalid && !aw_full_q) begin
        aw_full_q   <= 1'b1;
        wr_q.addr   <= awaddr;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
      if (wvalid && !w_full_q) begin
        w_full_q  <= 1'b1;
        wr_q.data <= wdata;
        wr_q.strb <= wstrb;
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata  <= rd_data;
        rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // wws_axil
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the windowed supervisor
`default_nettype none
module tb import wws_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, rst, awv, wv, bre, arv, rre, hw, hro, hlt, wk, rls;
  logic              awr, wr_rdy, bv, arr, rv, rstn, irq;
  logic [ADDR_W-1:0] awa, ara;
  logic [31:0]       wd, rd;
  logic [1:0]        br, rr, tb_sel;
  int                failures, cmp_count, cyc;

  wws_windowed_supervisor wws_windowed_supervisor_i (
    .CLK(clk), .SYS_RST(rst),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
    .HW_ACTIVATE_OPT(hw), .HALT_RESET_OPTION(hro), .HALT_EXEC(hlt),
    .WAKE_IRQ(wk), .RESUME_LONG_SEL(rls), .TIMEBASE_SELECT(tb_sel),
    .SUPERVISOR_RESET_N(rstn), .IRQ(irq)
  );

  always #4 clk = ~clk;

  // Hang guard: the planned tests need roughly 82000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      failures++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awr === 1'b1) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (!dd && wr_rdy === 1'b1) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    resp = br;
    bre <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rd;
    resp = rr;
    rre <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(d, e, m);
  endtask

  task automatic do_rst();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Option pins need two edges through their synchronisers after release
    repeat (3) @(posedge clk);
  endtask

  // Cycles until the reset output falls, then how long it stays low
  task automatic wait_pulse(input int bound, output int at, output int len);
    at = 0;
    len = 0;
    while (rstn !== 1'b0 && at < bound) begin
      @(posedge clk);
      at++;
    end
    while (rstn === 1'b0) begin
      @(posedge clk);
      len++;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          at, len, e, lo, hi;
    int          wq[$];
    clk = 1'b0;
    rst = 1'b1;
    {awv, wv, bre, arv, rre, hw, hro, hlt, wk, rls} = '0;
    awa = '0;
    ara = '0;
    wd = '0;
    tb_sel = 2'h0;
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    void'($urandom(32'h93D7));
    do_rst();
    chk(rstn, 1, "reset out idle");
    chk(irq, 0, "irq idle");
    rdc(ADDR_CTRL, 32'h7F, "ctrl reset");
    rdc(ADDR_WIN, 32'h7F, "window reset");
    rdc(ADDR_STAT, 32'h0, "status reset");
    rdc(ADDR_MASK, 32'h0, "mask reset");
    rdc(ADDR_INFO, 32'h0, "starts inactive");
    axr(8'h14, d, r);
    chk(r, RESP_SLVERR, "unmapped read resp");
    chk(d, 32'h0, "unmapped read data");
    axw(8'h14, 32'hFF, r);
    chk(r, RESP_SLVERR, "unmapped write resp");
    $display("reset values done");

    // Free-running count while inactive, no reset may follow
    repeat (16200) @(posedge clk);
    rdc(ADDR_CTRL, 32'h7F, "before first step");
    repeat (300) @(posedge clk);
    rdc(ADDR_CTRL, 32'h7E, "after first step");
    chk(rstn, 1, "inactive no reset");
    $display("free run done");

    do_rst();
    wr(ADDR_CTRL, 32'hFF);
    rdc(ADDR_INFO, 32'h1, "software activation");
    wr(ADDR_CTRL, 32'h7F);
    rdc(ADDR_CTRL, 32'hFF, "activation sticky");
    chk(rstn, 1, "reload inside window");
    hro <= 1'b1;
    repeat (3) @(posedge clk);
    hlt <= 1'b1;
    repeat (4) @(posedge clk);
    hlt <= 1'b0;
    wait_pulse(20, at, len);
    chk(len, RST_PULSE_CYC, "halt reset pulse");
    rdc(ADDR_STAT, 32'h8, "halt cause");
    hro <= 1'b0;
    $display("activation and halt done");

    do_rst();
    wr(ADDR_CTRL, 32'hBF);
    wait_pulse(20, at, len);
    chk(len > 0, 1, "software reset");
    chk(irq, 0, "masked irq");
    rdc(ADDR_STAT, 32'h4, "software cause");
    wr(ADDR_MASK, 32'h4);
    chk(irq, 1, "unmasked irq");
    wr(ADDR_STAT, 32'h4);
    chk(irq, 0, "irq cleared");
    rdc(ADDR_STAT, 32'h0, "status cleared");
    $display("software reset done");

    hw <= 1'b1;
    do_rst();
    axr(ADDR_INFO, d, r);
    chk(d[0], 1, "hardware active");
    wr(ADDR_WIN, 32'h50);
    rdc(ADDR_WIN, 32'h50, "window readback");
    wr(ADDR_CTRL, 32'h7F);
    wait_pulse(20, at, len);
    chk(len > 0, 1, "early reload");
    rdc(ADDR_STAT, 32'h2, "early cause");
    $display("early reload done");

    // Model: right after reset the count is 7Fh, so a reload fires iff window < 7Fh
    wq = '{127};
    repeat (3) wq.push_back($urandom % 128);
    foreach (wq[i]) begin
      tb_sel <= 2'($urandom % 4);
      do_rst();
      wr(ADDR_WIN, 32'(wq[i]));
      wr(ADDR_CTRL, 32'hFF);
      e = (127 > wq[i]) ? 1 : 0;
      wait_pulse(10, at, len);
      chk(len > 0, e, "random window reset");
      rdc(ADDR_STAT, 32'(e * 2), "random window cause");
    end
    $display("random windows done");

    tb_sel <= 2'h0;
    do_rst();
    wr(ADDR_CTRL, 32'hC1);
    // Two steps: stretched first interval, then a plain or short one
    lo = (59 + 128) * 64 + (192 + 59) * 64 - 8;
    hi = 2 * 16384 + 8;
    wait_pulse(40000, at, len);
    chk(at >= lo && at <= hi, 1, "expiry time");
    chk(len, RST_PULSE_CYC, "expiry pulse");
    rdc(ADDR_STAT, 32'h1, "expiry cause");
    $display("expiry done");

    // Halt without the reset option, then a wake edge and the resume wait
    for (int k = 0; k < 2; k++) begin
      rls <= 1'(k);
      do_rst();
      wr(ADDR_CTRL, 32'hFF);
      hlt <= 1'b1;
      repeat (4) @(posedge clk);
      hlt <= 1'b0;
      rdc(ADDR_INFO, 32'h3, "halted without reset");
      wk <= 1'b1;
      lo = k ? 4096 : 256;
      repeat (lo - 20) @(posedge clk);
      rdc(ADDR_INFO, 32'h3, "still resuming");
      repeat (30) @(posedge clk);
      rdc(ADDR_INFO, 32'h1, "counting again");
      wk <= 1'b0;
      chk(rstn, 1, "halt without reset option");
    end
    $display("halt and wake done");
    stop_test();
  end
endmodule // tb
`default_nettype wire
